/* File: hdl/data_fault_status_lpae_regs.svh */
`ifndef FAULT_STATUS_REGS_SVH
`define FAULT_STATUS_REGS_SVH

// coprocessor access selector for this register
`define DFS_CP_OPC1 3'h0
`define DFS_CP_CRN 4'h5
`define DFS_CP_CRM 4'h0
`define DFS_CP_OPC2 3'h0

// field positions
`define DFS_CACHE_MAINT_BIT 13
`define DFS_ABORT_TYPE_BIT 12
`define DFS_WRITE_BIT 11
`define DFS_ONE_BIT 9
`define DFS_STATUS_LSB 0
`define DFS_STATUS_MSB 5

// reset value, bit 9 reads one
`define DFS_RESET_VAL 32'h0000_0200
// bits kept by software writes
`define DFS_WRITE_MASK 32'h0000_383F

// status upper bits, lookup level appended
`define DFS_ST_TRANS 4'h1
`define DFS_ST_ACCFLAG 4'h2
`define DFS_ST_PERM 4'h3
`define DFS_ST_WALK_EXTERNAL 4'h5
`define DFS_ST_WALK_PARITY 4'h7
// full six-bit status codes
`define DFS_ST_SYNC_EXTERNAL 6'h10
`define DFS_ST_SYNC_PARITY 6'h18
`define DFS_ST_ASYNC_EXTERNAL 6'h11
`define DFS_ST_ASYNC_PARITY 6'h19
`define DFS_ST_ALIGN 6'h21
`define DFS_ST_DEBUG 6'h22

`endif

/* File: hdl/data_fault_status_lpae_pkg.sv */
package fault_status_pkg;

  typedef enum logic [3:0] {
    FAULT_TRANSLATION = 4'h0,
    FAULT_ACCESS_FLAG = 4'h1,
    FAULT_PERMISSION = 4'h2,
    FAULT_SYNC_EXTERNAL = 4'h3,
    FAULT_SYNC_PARITY = 4'h4,
    FAULT_ASYNC_EXTERNAL = 4'h5,
    FAULT_ASYNC_PARITY = 4'h6,
    FAULT_WALK_EXTERNAL = 4'h7,
    FAULT_WALK_PARITY = 4'h8,
    FAULT_ALIGNMENT = 4'h9,
    FAULT_DEBUG = 4'hA
  } fault_kind_type;

  typedef enum logic [1:0] {
    LEVEL_FIRST = 2'h1,
    LEVEL_SECOND = 2'h2,
    LEVEL_THIRD = 2'h3
  } lookup_level_type;

  // one data abort report
  typedef struct packed {
    fault_kind_type kind;
    lookup_level_type lookup_level;
    logic write_not_read;
    logic cache_maint;
    logic slave_error;
  } abort_report_type;

  // coprocessor move request
  typedef struct packed {
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
  } cp_select_type;

endpackage

/* File: hdl/data_fault_status.sv */
// Functional notes
// - synchronous fault: cache bit is 1 if maintenance op caused it, else 0.
// - asynchronous fault: cache bit undefined; here it is written 0.
// - external abort: type bit 0 for decode error, 1 for slave error.
// - non-external aborts report external-abort-type bit as zero.
// - write-not-read bit is 0 for read abort, 1 for write abort.
// - cache maintenance and translation-op faults always report write-not-read as 1; only cache_maint forces it here, there is no translation-op input.
// - six-bit status field holds fault type; reserved codes never produced.
// - translation, access flag, permission faults: four fixed bits plus lookup level.
// - sync external abort 010000, sync parity error 011000.
// - async external abort 010001, async parity error 011001.
// - walk external abort and walk parity error: fixed bits plus lookup level.
// - lookup level 01 first, 10 second, 11 third; 00 never produced.
// - software reads and writes via coprocessor move op1 0, c5, c0, op2 0.
`include "data_fault_status_lpae_regs.svh"

module data_fault_status (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // abort report from the load/store and walk path
  input wire logic i_abort_valid,
  input wire fault_status_pkg::abort_report_type i_abort,
  // coprocessor move port
  input wire logic i_cp_read,
  input wire logic i_cp_write,
  input wire fault_status_pkg::cp_select_type i_cp_sel,
  input wire logic [31:0] i_cp_wdata,
  // read answer
  output logic [31:0] o_cp_rdata,
  output logic o_cp_rvalid,
  output logic o_cp_hit,
  // current register image
  output logic [31:0] o_data_fault_status
);

  // register state
  logic [31:0] data_fault_status_q;

  // decoded abort report
  logic [31:0] report_d;
  logic [5:0] status_d;
  logic [1:0] level;
  logic is_external;
  logic is_sync;
  logic cache_maint_bit;
  logic abort_type_bit;
  logic write_bit;

  // software access
  logic sel_hit;
  logic write_hit;
  logic read_hit;
  logic [31:0] write_value;
  logic [31:0] read_value;

  assign sel_hit = (i_cp_sel.opc1 == `DFS_CP_OPC1)
    && (i_cp_sel.crn == `DFS_CP_CRN)
    && (i_cp_sel.crm == `DFS_CP_CRM)
    && (i_cp_sel.opc2 == `DFS_CP_OPC2);
  assign write_hit = i_cp_write & sel_hit;
  assign read_hit = i_cp_read & sel_hit;

  // level 00 is reserved, so it is coerced to first level
  always_comb begin
    if (i_abort.lookup_level == 2'h0) begin
      level = 2'h1;
    end else begin
      level = i_abort.lookup_level;
    end
  end

  // status code per fault kind
  always_comb begin
    status_d = `DFS_ST_ALIGN;
    unique case (i_abort.kind)
      fault_status_pkg::FAULT_TRANSLATION: begin
        status_d = {`DFS_ST_TRANS, level};
      end
      fault_status_pkg::FAULT_ACCESS_FLAG: begin
        status_d = {`DFS_ST_ACCFLAG, level};
      end
      fault_status_pkg::FAULT_PERMISSION: begin
        status_d = {`DFS_ST_PERM, level};
      end
      fault_status_pkg::FAULT_SYNC_EXTERNAL: begin
        status_d = `DFS_ST_SYNC_EXTERNAL;
      end
      fault_status_pkg::FAULT_SYNC_PARITY: begin
        status_d = `DFS_ST_SYNC_PARITY;
      end
      fault_status_pkg::FAULT_ASYNC_EXTERNAL: begin
        status_d = `DFS_ST_ASYNC_EXTERNAL;
      end
      fault_status_pkg::FAULT_ASYNC_PARITY: begin
        status_d = `DFS_ST_ASYNC_PARITY;
      end
      fault_status_pkg::FAULT_WALK_EXTERNAL: begin
        status_d = {`DFS_ST_WALK_EXTERNAL, level};
      end
      fault_status_pkg::FAULT_WALK_PARITY: begin
        status_d = {`DFS_ST_WALK_PARITY, level};
      end
      fault_status_pkg::FAULT_ALIGNMENT: begin
        status_d = `DFS_ST_ALIGN;
      end
      fault_status_pkg::FAULT_DEBUG: begin
        status_d = `DFS_ST_DEBUG;
      end
      // undefined kinds fall back to a defined code, never a reserved one
      default: begin
        status_d = `DFS_ST_ALIGN;
      end
    endcase
  end

  // external and synchronous classification
  always_comb begin
    is_external = 1'b0;
    is_sync = 1'b1;
    unique case (i_abort.kind)
      fault_status_pkg::FAULT_SYNC_EXTERNAL: begin
        is_external = 1'b1;
      end
      fault_status_pkg::FAULT_SYNC_PARITY: begin
        is_external = 1'b0;
        is_sync = 1'b1;
      end
      fault_status_pkg::FAULT_ASYNC_EXTERNAL: begin
        is_external = 1'b1;
        is_sync = 1'b0;
      end
      fault_status_pkg::FAULT_ASYNC_PARITY: begin
        is_sync = 1'b0;
      end
      fault_status_pkg::FAULT_WALK_EXTERNAL: begin
        is_external = 1'b1;
      end
      fault_status_pkg::FAULT_WALK_PARITY: begin
        is_external = 1'b0;
        is_sync = 1'b1;
      end
      default: begin
        is_external = 1'b0;
        is_sync = 1'b1;
      end
    endcase
  end

  // cache bit is undefined on asynchronous faults; zero is stored
  assign cache_maint_bit = is_sync & i_abort.cache_maint;
  assign abort_type_bit = is_external & i_abort.slave_error;
  assign write_bit = i_abort.write_not_read | i_abort.cache_maint;

  // report image, fixed bits taken from the reset value
  always_comb begin
    report_d = `DFS_RESET_VAL;
    report_d[`DFS_STATUS_MSB:`DFS_STATUS_LSB] = status_d;
    report_d[`DFS_CACHE_MAINT_BIT] = cache_maint_bit;
    report_d[`DFS_ABORT_TYPE_BIT] = abort_type_bit;
    report_d[`DFS_WRITE_BIT] = write_bit;
  end

  // software write: writable bits follow data, fixed bits keep reset level
  for (genvar b = 0; b < 32; b++) begin : g_write_bit
    localparam logic [31:0] KEEP = `DFS_WRITE_MASK;
    localparam logic [31:0] FIXED = `DFS_RESET_VAL;
    assign write_value[b] = KEEP[b] ? i_cp_wdata[b] : FIXED[b];
  end

  // a selector miss reads as zero
  assign read_value = read_hit ? data_fault_status_q : 32'h0000_0000;

  // abort report wins over a software write in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      data_fault_status_q <= `DFS_RESET_VAL;
    end else if (i_abort_valid) begin
      data_fault_status_q <= report_d;
    end else if (write_hit) begin
      data_fault_status_q <= write_value;
    end
  end

  // image output mirrors the register
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_data_fault_status <= `DFS_RESET_VAL;
    end else if (i_abort_valid) begin
      o_data_fault_status <= report_d;
    end else if (write_hit) begin
      o_data_fault_status <= write_value;
    end
  end

  // read data, one cycle after the move
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_cp_rdata <= 32'h0000_0000;
    end else begin
      o_cp_rdata <= read_value;
    end
  end

  // read answer strobe
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_cp_rvalid <= 1'b0;
    end else begin
      o_cp_rvalid <= i_cp_read;
    end
  end

  // selector match on any move
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_cp_hit <= 1'b0;
    end else begin
      o_cp_hit <= read_hit | write_hit;
    end
  end

endmodule // data_fault_status

/* File: test/data_fault_status_props.sv */
module data_fault_status_props (
  input wire logic i_ref_clk, i_nrst, i_abort_valid, i_cp_read, i_cp_write,
  input wire fault_status_pkg::abort_report_type i_abort,
  input wire fault_status_pkg::cp_select_type i_cp_sel,
  input wire logic [31:0] i_cp_wdata, o_cp_rdata, o_data_fault_status,
  input wire logic o_cp_rvalid, o_cp_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [31:0] r = o_data_fault_status;
  wire logic [3:0] k = i_abort.kind;
  wire logic v = i_abort_valid;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_rd; i_cp_read && i_cp_sel == 14'h0280; endsequence
  sequence s_ans; o_cp_rvalid && o_cp_hit; endsequence
  property p_cm; v && !(k inside {5, 6}) |=> r[13] == $past(i_abort.cache_maint); endproperty
  a_cm: assert property (p_cm) else $error("cm bit");
  property p_etype; v && k inside {3, 5, 7} |=> r[12] == $past(i_abort.slave_error); endproperty
  a_etype: assert property (p_etype) else $error("abort type bit");
  property p_ezero; v && !(k inside {3, 5, 7}) |=> !r[12]; endproperty
  a_ezero: assert property (p_ezero) else $error("abort type not zero");
  property p_wnr; v |=> r[11] == $past(i_abort.write_not_read || i_abort.cache_maint); endproperty
  a_wnr: assert property (p_wnr) else $error("write bit");
  property p_lvl; v && k < 3 |=> r[5:0] == {$past(k) + 4'h1,
    $past(i_abort.lookup_level == 2'h0 ? 2'h1 : i_abort.lookup_level)}; endproperty
  a_lvl: assert property (p_lvl) else $error("level code");
  property p_sp; v && k == 4 |=> r[5:0] == 6'h18; endproperty
  a_sp: assert property (p_sp) else $error("parity code");
  property p_rao; r[10:6] == 5'h08; endproperty
  a_rao: assert property (p_rao) else $error("fixed bits");
  property p_rd; s_rd |=> s_ans ##0 o_cp_rdata == $past(r); endproperty
  a_rd: assert property (p_rd) else $error("read answer");
endmodule // data_fault_status_props
bind data_fault_status data_fault_status_props u_data_fault_status_props (.*);

/* File: test/abort_source.sv */
module abort_source (
  input wire logic i_ref_clk,
  input wire logic i_go,
  input wire logic [8:0] i_rnd,
  output logic o_valid,
  output fault_status_pkg::abort_report_type o_rep
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 0;
    o_rep = '0;
  end
  // idle report lines show the inverse of the last value
  always @(negedge i_ref_clk) begin
    o_valid <= i_go;
    o_rep <= i_go ? i_rnd : ~o_rep;
  end
endmodule // abort_source

/* File: test/data_fault_status_tb.sv */
module data_fault_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 0, i_nrst = 0, i_cp_read = 0, i_cp_write = 0, go = 0;
  wire logic i_abort_valid;
  wire fault_status_pkg::abort_report_type i_abort;
  fault_status_pkg::cp_select_type i_cp_sel = 14'h0280;
  logic [31:0] i_cp_wdata = 0, o_cp_rdata, o_data_fault_status, seed = 32'h6ca3_bb7f, x, e;
  logic [8:0] rnd = 0;
  logic o_cp_rvalid, o_cp_hit;
  int miscompares = 0, num_checks = 0, cyc = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  data_fault_status u_data_fault_status (.*);
  abort_source u_abort_source (.i_ref_clk, .i_go(go), .i_rnd(rnd), .o_valid(i_abort_valid),
    .o_rep(i_abort));
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ck(string n, logic [31:0] ex_v, logic [31:0] g);
    num_checks++;
    if (g !== ex_v) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, ex_v, g);
    end
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      test_done();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] ex(logic [8:0] r);
    logic [5:0] s;
    logic [3:0] k;
    logic [1:0] l;
    k = r[8:5];
    l = (r[4:3] == 2'h0) ? 2'h1 : r[4:3];
    case (k)
      0, 1, 2: s = {k + 4'h1, l};
      3: s = 6'h10;
      4: s = 6'h18;
      5: s = 6'h11;
      6: s = 6'h19;
      7: s = {4'h5, l};
      8: s = {4'h7, l};
      9: s = 6'h21;
      10: s = 6'h22;
      default: s = 6'h21;
    endcase
    return {18'h0, r[1] && !(k inside {5, 6}), r[0] && k inside {3, 5, 7}, r[2] | r[1], 5'h08, s};
  endfunction
  task automatic ab(logic [8:0] r);
    logic [31:0] m;
    m = (r[8:5] inside {5, 6}) ? 32'hffff_dfff : 32'hffff_ffff;
    @(posedge i_ref_clk);
    go <= 1;
    rnd <= r;
    @(posedge i_ref_clk);
    go <= 0;
    @(posedge i_ref_clk);
    #1 ck("status", ex(r) & m, o_data_fault_status & m);
  endtask
  task automatic cp(logic w, logic [13:0] s, logic [31:0] d);
    @(negedge i_ref_clk);
    i_cp_write = w;
    i_cp_read = !w;
    i_cp_sel = s;
    i_cp_wdata = d;
    @(negedge i_ref_clk);
    i_cp_write = 0;
    i_cp_read = 0;
  endtask
  initial begin
    repeat (20) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_nrst = 1;
    ck("reset", 32'h0000_0200, o_data_fault_status);
    for (int i = 0; i < 73; i++) begin
      x = xs();
      ab(i < 33 ? {4'(i / 3), 2'(i % 3 + 1), x[2:0]} : {4'(x[7:4] % 11), 2'(x[9:8] % 3 + 1), x[2:0]});
    end
    for (int i = 0; i < 5; i++) begin
      ab({4'(11 + i), 2'h0, 3'(i)});
    end
    ab({4'h7, 2'h0, 3'h1});
    for (int i = 0; i < 6; i++) begin
      x = xs();
      e = x & 32'h0000_383f | 32'h0000_0200;
      cp(1, 14'h0280, x);
      ck("wr", e, o_data_fault_status);
      cp(0, i[0] ? 14'h0280 : 14'(x[13:0] | 14'h0100), 0);
      ck("rv", {30'h0, 1'b1, i[0]}, {30'h0, o_cp_rvalid, o_cp_hit});
      ck("rdata", i[0] ? e : 32'h0, o_cp_rdata);
    end
    test_done();
  end
endmodule // data_fault_status_tb
